// ### ums_pkg.sv
// ums_pkg: register map, field positions and reset values of the modem status pin block
package ums_pkg;
  localparam int          UMS_NCH        = 2;
  localparam int          UMS_CH_BIT     = 5;
  localparam logic [4:0]  UMS_OFF_MSR    = 5'h00;
  localparam logic [4:0]  UMS_OFF_MCR    = 5'h04;
  localparam logic [4:0]  UMS_OFF_EXTENDED_CONTROL_1  = 5'h08;
  localparam logic [4:0]  UMS_OFF_MASK   = 5'h0C;
  localparam logic [4:0]  UMS_OFF_DIV    = 5'h10;
  localparam int          UMS_MSR_CTS_CHG = 0;
  localparam int          UMS_MSR_DSR_CHG = 1;
  localparam int          UMS_MSR_DCD_CHG = 3;
  localparam int          UMS_MSR_CTS    = 4;
  localparam int          UMS_MSR_DSR    = 5;
  localparam int          UMS_MSR_DCD    = 7;
  localparam int          UMS_MCR_DTR    = 0;
  localparam int          UMS_MCR_LOOP   = 4;
  localparam int          UMS_EXTENDED_CONTROL_1_BAUD_TEST_ENABLE = 7;
  localparam logic [7:0]  UMS_MCR_RST    = 8'h00;
  localparam logic [7:0]  UMS_EXTENDED_CONTROL_1_RST  = 8'h00;
  localparam logic [7:0]  UMS_MASK_RST   = 8'h00;
  localparam logic [7:0]  UMS_MASK_BITS  = 8'h0B;
  localparam logic [15:0] UMS_DIV_RST    = 16'h000C;
endpackage

// ### ums_change_flags.sv
// ums_change_flags: sticky change detectors for the three modem status inputs of one channel
`timescale 1ns/100ps
module ums_change_flags
  import ums_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [2:0] level,
  input  wire logic [2:0] clr,
  output logic [2:0]      flag_ff
);
  logic [2:0] prev_ff;
  logic       primed_ff;
  logic [2:0] nxt_flag;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prev_ff   <= 3'h7;
      primed_ff <= 1'b0;
    end
    else
    begin
      prev_ff   <= level;
      primed_ff <= 1'b1;
    end
  end

  // only bits that were returned by the read are cleared; a new change wins
  always_comb
  begin
    nxt_flag = (primed_ff ? (level ^ prev_ff) : 3'h0) | (flag_ff & ~clr);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      flag_ff <= 3'h0;
    else
      flag_ff <= nxt_flag;
  end
endmodule

// ### ums_baud_gen.sv
// ums_baud_gen: programmable divider giving a baud tick and a square baud clock
`timescale 1ns/100ps
module ums_baud_gen
  import ums_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] divisor,
  output logic             tick_ff,
  output logic             baud_ff
);
  logic [15:0] cnt_ff;
  logic        wrap;

  always_comb
  begin
    wrap = (divisor != 16'h0000) && (cnt_ff <= 16'h0001);
  end

  // a divisor of zero stops the generator
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_ff <= 16'h0000;
    else if (wrap)
      cnt_ff <= divisor;
    else if (cnt_ff != 16'h0000)
      cnt_ff <= cnt_ff - 16'h0001;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tick_ff <= 1'b0;
      baud_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= wrap;
      baud_ff <= baud_ff ^ wrap;
    end
  end
endmodule

// ### ums_modem_pins.sv
// ums_modem_pins: apb register file, modem status pins, terminal-ready and baud-out mux of two channels
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
module ums_modem_pins
  import ums_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic [1:0]   cts_n,
  input  wire logic [1:0]   dsr_n,
  input  wire logic [1:0]   carrier_detect_n,
  input  wire logic [1:0]   serial_out,
  output logic [1:0]        baud_tick,
  output logic [1:0]        terminal_ready_n,
  output logic [1:0]        baud_clock_out,
  output logic              irq
);
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [1:0]  dtr_n_ff;
  logic [1:0]  baud_clock_out_ff;
  logic        irq_ff;
  logic [7:0]  mcr_ff   [UMS_NCH];
  logic [7:0]  extended_control_1_ff [UMS_NCH];
  logic [7:0]  mask_ff  [UMS_NCH];
  logic [15:0] div_ff   [UMS_NCH];
  logic [2:0]  chg      [UMS_NCH];
  logic [2:0]  clr      [UMS_NCH];
  logic [7:0]  modem_status_reg      [UMS_NCH];
  logic [1:0]  baud;
  logic        ch;
  logic [4:0]  off;
  logic        mapped;
  logic        acc_first;
  logic        acc_done;
  logic        wr_en;
  logic        rd_msr_done;
  logic [31:0] nxt_rdata;
  logic        nxt_irq;

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign terminal_ready_n = dtr_n_ff;
  assign baud_clock_out   = baud_clock_out_ff;
  assign irq              = irq_ff;

  // address decode; one wait state per transfer
  always_comb
  begin
    ch          = paddr[UMS_CH_BIT];
    off         = paddr[4:0];
    mapped      = (paddr[11:6] == 6'h00) && (off == UMS_OFF_MSR || off == UMS_OFF_MCR ||
                  off == UMS_OFF_EXTENDED_CONTROL_1 || off == UMS_OFF_MASK || off == UMS_OFF_DIV);
    acc_first   = psel && penable && !pready_ff;
    acc_done    = psel && penable && pready_ff;
    wr_en       = acc_done && pwrite && mapped;
    rd_msr_done = acc_done && !pwrite && mapped && (off == UMS_OFF_MSR);
  end

  genvar g;
  generate
    for (g = 0; g < UMS_NCH; g++)
    begin : g_ch
      ums_change_flags u_flags (
        .clock   (clock),
        .rst     (rst),
        .level   ({carrier_detect_n[g], dsr_n[g], cts_n[g]}),
        .clr     (clr[g]),
        .flag_ff (chg[g])
      );
      ums_baud_gen u_baud (
        .clock   (clock),
        .rst     (rst),
        .divisor (div_ff[g]),
        .tick_ff (baud_tick[g]),
        .baud_ff (baud[g])
      );
      always_comb
      begin
        modem_status_reg[g] = 8'h00;
        modem_status_reg[g][UMS_MSR_CTS]     = ~cts_n[g];
        modem_status_reg[g][UMS_MSR_DSR]     = ~dsr_n[g];
        modem_status_reg[g][UMS_MSR_DCD]     = ~carrier_detect_n[g];
        modem_status_reg[g][UMS_MSR_CTS_CHG] = chg[g][0];
        modem_status_reg[g][UMS_MSR_DSR_CHG] = chg[g][1];
        modem_status_reg[g][UMS_MSR_DCD_CHG] = chg[g][2];
        // clear exactly the flags captured in the returned word
        clr[g] = (rd_msr_done && ch == 1'(g)) ?
                 {prdata_ff[UMS_MSR_DCD_CHG], prdata_ff[UMS_MSR_DSR_CHG], prdata_ff[UMS_MSR_CTS_CHG]} :
                 3'h0;
      end
    end
  endgenerate

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    unique case (off)
      UMS_OFF_MSR:   nxt_rdata[7:0]  = modem_status_reg[ch];
      UMS_OFF_MCR:   nxt_rdata[7:0]  = mcr_ff[ch];
      UMS_OFF_EXTENDED_CONTROL_1: nxt_rdata[7:0]  = extended_control_1_ff[ch];
      UMS_OFF_MASK:  nxt_rdata[7:0]  = mask_ff[ch];
      UMS_OFF_DIV:   nxt_rdata[15:0] = div_ff[ch];
      default:       nxt_rdata       = 32'h0000_0000;
    endcase
    if (!mapped)
      nxt_rdata = 32'h0000_0000;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= acc_first;
      pslverr_ff <= acc_first && !mapped;
      if (acc_first && !pwrite)
        prdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < UMS_NCH; i++)
      begin
        mcr_ff[i]   <= UMS_MCR_RST;
        extended_control_1_ff[i] <= UMS_EXTENDED_CONTROL_1_RST;
        mask_ff[i]  <= UMS_MASK_RST;
        div_ff[i]   <= UMS_DIV_RST;
      end
    end
    else if (wr_en)
    begin
      unique case (off)
        UMS_OFF_MCR:   mcr_ff[ch]   <= pwdata[7:0];
        UMS_OFF_EXTENDED_CONTROL_1: extended_control_1_ff[ch] <= pwdata[7:0];
        UMS_OFF_MASK:  mask_ff[ch]  <= pwdata[7:0] & UMS_MASK_BITS;
        UMS_OFF_DIV:   div_ff[ch]   <= pwdata[15:0];
        default:       ;
      endcase
    end
  end

  // terminal-ready: active low, forced inactive in loopback
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      dtr_n_ff <= 2'h3;
    else
      for (int i = 0; i < UMS_NCH; i++)
        dtr_n_ff[i] <= ~(mcr_ff[i][UMS_MCR_DTR] & ~mcr_ff[i][UMS_MCR_LOOP]);
  end

  // serial output passes untouched by clear-to-send unless the baud test is on
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      baud_clock_out_ff <= 2'h3;
    else
      for (int i = 0; i < UMS_NCH; i++)
        baud_clock_out_ff[i] <= extended_control_1_ff[i][UMS_EXTENDED_CONTROL_1_BAUD_TEST_ENABLE] ? baud[i] : serial_out[i];
  end

  always_comb
  begin
    nxt_irq = 1'b0;
    for (int i = 0; i < UMS_NCH; i++)
      nxt_irq = nxt_irq | (|(modem_status_reg[i][3:0] & mask_ff[i][3:0]));
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= nxt_irq;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_msr_setup;
    acc_first && !pwrite && mapped && off == UMS_OFF_MSR && ch == 1'b0;
  endsequence

  sequence s_msr_read;
    s_msr_setup ##0 $stable(cts_n[0]) ##1 rd_msr_done ##0 $stable(cts_n[0]);
  endsequence

  property p_read_cts;
    s_msr_setup |=> prdata_ff[UMS_MSR_CTS] == ~$past(cts_n[0]);
  endproperty
  a_read_cts: assert property (p_read_cts) else $error("cts level misreported");

  property p_read_dcd;
    s_msr_setup |=> prdata_ff[UMS_MSR_DCD] == ~$past(carrier_detect_n[0]);
  endproperty
  a_read_dcd: assert property (p_read_dcd) else $error("carrier level misreported");

  property p_read_dsr;
    s_msr_setup |=> prdata_ff[UMS_MSR_DSR] == ~$past(dsr_n[0]) && pready_ff;
  endproperty
  a_read_dsr: assert property (p_read_dsr) else $error("set-ready level misreported");

  property p_cts_change;
    (cts_n[0] != $past(cts_n[0])) && !$past(rst) |-> ##1 chg[0][0] ##1 modem_status_reg[0][UMS_MSR_CTS_CHG];
  endproperty
  a_cts_change: assert property (p_cts_change) else $error("cts change not flagged");

  property p_dcd_hold;
    chg[0][2] && !rd_msr_done |=> chg[0][2];
  endproperty
  a_dcd_hold: assert property (p_dcd_hold) else $error("carrier change flag lost");

  property p_irq;
    (chg[0][0] && mask_ff[0][0]) || (chg[0][2] && mask_ff[0][3]) |=> irq_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled modem event raised no interrupt");

  property p_read_clear;
    s_msr_read |=> !chg[0][0];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear cts flag");

  property p_loop_dtr;
    mcr_ff[0][UMS_MCR_LOOP] [*2] |-> terminal_ready_n[0];
  endproperty
  a_loop_dtr: assert property (p_loop_dtr) else $error("terminal-ready active in loopback");

  property p_baud_test_enable;
    extended_control_1_ff[0][UMS_EXTENDED_CONTROL_1_BAUD_TEST_ENABLE] |=> baud_clock_out_ff[0] == $past(baud[0]);
  endproperty
  a_baud_test_enable: assert property (p_baud_test_enable) else $error("baud clock not on pin");

  property p_passthru;
    !extended_control_1_ff[0][UMS_EXTENDED_CONTROL_1_BAUD_TEST_ENABLE] |=> baud_clock_out_ff[0] == $past(serial_out[0]);
  endproperty
  a_passthru: assert property (p_passthru) else $error("serial output altered");

  sequence s_msr_setup1;
    acc_first && !pwrite && mapped && off == UMS_OFF_MSR && ch == 1'b1;
  endsequence

  property p_read_cts1;
    s_msr_setup1 |=> prdata_ff[UMS_MSR_CTS] == ~$past(cts_n[1]);
  endproperty
  a_read_cts1: assert property (p_read_cts1) else $error("channel 1 cts level misreported");

  property p_read_dcd1;
    s_msr_setup1 |=> prdata_ff[UMS_MSR_DCD] == ~$past(carrier_detect_n[1]);
  endproperty
  a_read_dcd1: assert property (p_read_dcd1) else $error("channel 1 carrier level misreported");

  property p_read_dsr1;
    s_msr_setup1 |=> prdata_ff[UMS_MSR_DSR] == ~$past(dsr_n[1]);
  endproperty
  a_read_dsr1: assert property (p_read_dsr1) else $error("channel 1 set-ready level misreported");

  property p_read_chg;
    s_msr_setup |=> prdata_ff[3:0] == {$past(chg[0][2]), 1'b0, $past(chg[0][1]), $past(chg[0][0])};
  endproperty
  a_read_chg: assert property (p_read_chg) else $error("changed flags misplaced in status word");

  property p_read_pad;
    s_msr_setup |=> prdata_ff[31:8] == 24'h000000 && !prdata_ff[2] && !prdata_ff[6];
  endproperty
  a_read_pad: assert property (p_read_pad) else $error("unused status bits not zero");

  property p_dsr_change;
    (dsr_n[0] != $past(dsr_n[0])) && !$past(rst) |=> chg[0][1];
  endproperty
  a_dsr_change: assert property (p_dsr_change) else $error("set-ready change not flagged");

  property p_dcd_change;
    (carrier_detect_n[0] != $past(carrier_detect_n[0])) && !$past(rst) |=> chg[0][2];
  endproperty
  a_dcd_change: assert property (p_dcd_change) else $error("carrier change not flagged");

  property p_cts_quiet;
    $stable(cts_n[0]) && !chg[0][0] |=> !chg[0][0];
  endproperty
  a_cts_quiet: assert property (p_cts_quiet) else $error("cts change flag set without a change");

  property p_dcd_quiet;
    $stable(carrier_detect_n[0]) && !chg[0][2] |=> !chg[0][2];
  endproperty
  a_dcd_quiet: assert property (p_dcd_quiet) else $error("carrier change flag set without a change");

  property p_cts_change1;
    (cts_n[1] != $past(cts_n[1])) && !$past(rst) |=> chg[1][0];
  endproperty
  a_cts_change1: assert property (p_cts_change1) else $error("channel 1 cts change not flagged");

  property p_irq_quiet;
    !(|(modem_status_reg[0][3:0] & mask_ff[0][3:0])) && !(|(modem_status_reg[1][3:0] & mask_ff[1][3:0])) |=> !irq_ff;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without an enabled event");

  property p_loop_dtr1;
    mcr_ff[1][UMS_MCR_LOOP] [*2] |-> terminal_ready_n[1];
  endproperty
  a_loop_dtr1: assert property (p_loop_dtr1) else $error("channel 1 terminal-ready active in loopback");

  property p_dtr_on;
    (mcr_ff[0][UMS_MCR_DTR] && !mcr_ff[0][UMS_MCR_LOOP]) [*2] |-> !terminal_ready_n[0];
  endproperty
  a_dtr_on: assert property (p_dtr_on) else $error("terminal-ready not driven low");

  property p_dtr_on1;
    (mcr_ff[1][UMS_MCR_DTR] && !mcr_ff[1][UMS_MCR_LOOP]) [*2] |-> !terminal_ready_n[1];
  endproperty
  a_dtr_on1: assert property (p_dtr_on1) else $error("channel 1 terminal-ready not driven low");

  property p_passthru1;
    !extended_control_1_ff[1][UMS_EXTENDED_CONTROL_1_BAUD_TEST_ENABLE] |=> baud_clock_out_ff[1] == $past(serial_out[1]);
  endproperty
  a_passthru1: assert property (p_passthru1) else $error("channel 1 serial output altered");

  property p_wait;
    acc_first |=> pready_ff;
  endproperty
  a_wait: assert property (p_wait) else $error("access not answered after one wait state");

  property p_ready_pulse;
    pready_ff |=> !pready_ff;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held longer than one cycle");

  property p_slverr;
    acc_first && !mapped |=> pslverr_ff && pready_ff;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");

  property p_mask_write;
    wr_en && off == UMS_OFF_MASK && ch == 1'b0 |=> mask_ff[0] == ($past(pwdata[7:0]) & UMS_MASK_BITS);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("interrupt enable write lost");

  property p_baud_test_enable_write;
    wr_en && off == UMS_OFF_EXTENDED_CONTROL_1 && ch == 1'b0 |=> extended_control_1_ff[0][UMS_EXTENDED_CONTROL_1_BAUD_TEST_ENABLE] == $past(pwdata[UMS_EXTENDED_CONTROL_1_BAUD_TEST_ENABLE]);
  endproperty
  a_baud_test_enable_write: assert property (p_baud_test_enable_write) else $error("baud test bit write lost");
endmodule

// ### ums_modem_model.sv
// ums_modem_model: far-end modem driving handshake lines and a busy transmit line
`timescale 1ns/100ps
module ums_modem_model
(
  input  wire logic       clock,
  input  wire logic [5:0] want_n,
  output logic [1:0]      cts_n,
  output logic [1:0]      dsr_n,
  output logic [1:0]      carrier_detect_n,
  output logic [1:0]      serial_out
);
  logic [5:0] lines_ff = 6'h3F;
  logic [1:0] tx_ff    = 2'h1;

  assign {carrier_detect_n, dsr_n, cts_n} = lines_ff;
  assign serial_out                       = tx_ff;

  // lines move just after an edge; transmit line changes every cycle
  always @(posedge clock)
  begin
    lines_ff <= want_n;
    tx_ff    <= ~tx_ff;
  end
endmodule

// ### tb_top.sv
// tb_top: apb-driven checks of modem status, terminal-ready and baud-out pins
`timescale 1ns/100ps
module tb_top;
  import ums_pkg::*;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, irq, err, last;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  want_n;
  logic [1:0]  cts_n, dsr_n, carrier_detect_n, serial_out, baud_tick, terminal_ready_n, baud_clock_out;
  logic [31:0] lv [3] = '{32'h10, 32'h20, 32'h80};
  logic [31:0] cg [3] = '{32'h01, 32'h02, 32'h08};
  int          miscompares, n_checks, tg, tk;
  int          cycles = 0;

  ums_modem_pins uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cts_n(cts_n), .dsr_n(dsr_n), .carrier_detect_n(carrier_detect_n), .serial_out(serial_out),
    .baud_tick(baud_tick), .terminal_ready_n(terminal_ready_n), .baud_clock_out(baud_clock_out), .irq(irq));
  ums_modem_model modem (.clock(clock), .want_n(want_n), .cts_n(cts_n), .dsr_n(dsr_n),
    .carrier_detect_n(carrier_detect_n), .serial_out(serial_out));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      report_and_stop;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // entered just after an edge; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel in this step
    @(posedge clock);
  endtask

  task automatic rdchk(input string what, input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic baud_clock_out_chk(input string what);
    chk(what, {30'h0, ~serial_out}, {30'h0, baud_clock_out});
  endtask

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    want_n = 6'h3F;
    miscompares = 0;
    n_checks = 0;
    tick(16);
    chk("trdy_rst", 32'h3, {30'h0, terminal_ready_n});
    rst <= 1'b0;
    tick(2);
    baud_clock_out_chk("baud_clock_out_after_rst");
    rdchk("mcr_rst", 12'h004, 32'h0);
    rdchk("extended_control_1_rst", 12'h028, 32'h0);
    rdchk("mask_rst", 12'h00C, 32'h0);
    rdchk("div_rst", 12'h030, 32'h0000000C);
    rdchk("msr_idle", 12'h000, 32'h0);
    rdchk("unmapped_rd", 12'h014, 32'h0);
    chk("slverr_rd", 32'h1, {31'h0, err});
    apb(1'b1, 12'h044, 32'hFF);
    chk("slverr_wr", 32'h1, {31'h0, err});
    for (int l = 0; l < 3; l++)
      for (int c = 0; c < 2; c++)
      begin
        a = 12'(c * 32);
        want_n[2 * l + c] <= 1'b0;
        tick(3);
        baud_clock_out_chk("baud_clock_out_lines");
        rdchk("msr_set", a, lv[l] | cg[l]);
        rdchk("msr_held", a, lv[l]);
        want_n[2 * l + c] <= 1'b1;
        tick(3);
        rdchk("msr_back", a, cg[l]);
        rdchk("msr_quiet", a, 32'h0);
      end
    apb(1'b1, 12'h00C, 32'h0B);
    want_n[4] <= 1'b0;
    tick(4);
    chk("irq_on", 32'h1, {31'h0, irq});
    rdchk("msr_irq", 12'h000, 32'h88);
    tick(3);
    chk("irq_off", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h00C, 32'h0);
    want_n[4] <= 1'b1;
    tick(4);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdchk("msr_masked", 12'h000, 32'h08);
    apb(1'b1, 12'h024, 32'h01);
    tick(3);
    chk("trdy_on", 32'h1, {30'h0, terminal_ready_n});
    apb(1'b1, 12'h024, 32'h11);
    tick(3);
    chk("trdy_loop", 32'h3, {30'h0, terminal_ready_n});
    apb(1'b1, 12'h004, 32'h01);
    tick(3);
    chk("trdy_on0", 32'h2, {30'h0, terminal_ready_n});
    apb(1'b1, 12'h004, 32'h11);
    tick(3);
    chk("trdy_loop0", 32'h3, {30'h0, terminal_ready_n});
    apb(1'b1, 12'h024, 32'h01);
    apb(1'b1, 12'h010, 32'h4);
    apb(1'b1, 12'h008, 32'h80);
    tick(10);
    tg = 0;
    tk = 0;
    last = baud_clock_out[0];
    repeat (40)
    begin
      @(posedge clock);
      tk += int'(baud_tick[0]);
      tg += int'(baud_clock_out[0] != last);
      last = baud_clock_out[0];
    end
    chk("baud_toggles", 32'h0000000A, tg);
    chk("baud_ticks", 32'h0000000A, tk);
    chk("baud_clock_out_ch1", {31'h0, ~serial_out[1]}, {31'h0, baud_clock_out[1]});
    rst <= 1'b1;
    tick(2);
    chk("trdy_mid_rst", 32'h3, {30'h0, terminal_ready_n});
    rst <= 1'b0;
    tick(2);
    baud_clock_out_chk("baud_clock_out_mid_rst");
    rdchk("extended_control_1_mid_rst", 12'h008, 32'h0);
    report_and_stop;
  end
endmodule
